// File: idzgb_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - the low 16 bits of the z delta velocity read back as a read-only low word at 0x38.
// - the main word at 0x3a is twos complement over +/-400 m/s, zero is 0x0000, lsb 400/2^15.
// - in the 16-bit view positive values clip at 0x7fff and -400 m/s reads 0x8000.
// - main word over low word forms a 32-bit twos complement value clipped to 0x7fffffff..0x80000000.
// - both delta velocity words are read-only, not kept in flash, and host writes leave them alone.
// - user bias is added right after the factory stage, once per 2000 Hz internal sample.
// - factory coefficients have no register and cannot be read or written.
// - x gyro bias is read/write at 0x40 (low) and 0x42 (high), both reset to 0x0000.
// - y gyro bias is read/write at 0x44 (low) and 0x46 (high), both reset to zero.
// - z gyro bias is read/write at 0x48 (low) and 0x4a (high), both reset to zero.
// - each axis adds its high:low pair as one 32-bit correction to that gyro rate.
// - each axis bias is written independently without touching the others.
// - delta velocity is the trapezoidal sum over the decimation interval divided by twice fs.
module idzgb_regs
  import idzgb_pkg::*;
#(
  parameter int SMP_CYC_P = SMP_CYC
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // register port from the serial engine
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // factory corrected samples from the signal chain
  input  wire logic [31:0] accel_z_smp,
  input  wire logic [31:0] gyro_x_fact,
  input  wire logic [31:0] gyro_y_fact,
  input  wire logic [31:0] gyro_z_fact,
  input  wire logic [15:0] decimation_setting,
  // results
  output logic      [31:0] gyro_x_corr,
  output logic      [31:0] gyro_y_corr,
  output logic      [31:0] gyro_z_corr,
  output logic      [31:0] dvel_z,
  output logic             data_rdy,
  output logic             smp_tick
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_n_ff;

  // async assert, two flop release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // internal sample clock
  // ****************************************************************
  localparam logic [15:0] TICK_LAST = 16'(SMP_CYC_P - 1);
  logic [15:0] tick_cnt_ff;
  logic        smp_tick_ff;

  // one pulse every SMP_CYC_P clocks, 2000 Hz by default
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_cnt_ff <= 16'h0000;
      smp_tick_ff <= 1'b0;
    end else begin
      smp_tick_ff <= (tick_cnt_ff == TICK_LAST);
      tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end
  end

  // ****************************************************************
  // gyro bias words, flash copy lives outside this block
  // ****************************************************************
  logic [15:0]                 bias_ff [0:NUM_BIAS_WORDS-1];
  logic [NUM_AXES-1:0][31:0]   bias_pair;
  logic [5:0]                  word_idx;
  logic [5:0]                  bias_idx;
  logic                        bias_hit;

  assign word_idx = reg_addr[6:1];
  assign bias_idx = word_idx - ADDR_GX_LO[6:1];
  // delta velocity words fall outside this range, so host writes never reach them
  assign bias_hit = (word_idx >= ADDR_GX_LO[6:1]) && (word_idx <= ADDR_GZ_HI[6:1]);

  genvar wi;
  generate
    for (wi = 0; wi < NUM_BIAS_WORDS; wi++) begin : g_bias
      // each word has its own strobe so axes never disturb each other
      always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          bias_ff[wi] <= BIAS_RST;
        end else if (reg_wr && bias_hit && (bias_idx == 6'(wi))) begin
          bias_ff[wi] <= reg_wdata;
        end
      end
    end
    for (wi = 0; wi < NUM_AXES; wi++) begin : g_pair
      // high word on top, low word adds resolution below
      assign bias_pair[wi] = {bias_ff[2*wi+1], bias_ff[2*wi]};
    end
  endgenerate

  // ****************************************************************
  // correction chain and delta velocity
  // ****************************************************************
  logic [NUM_AXES-1:0][31:0] rate_corr;
  logic [31:0]               dvel_ff;
  logic                      dvel_vld_ff;

  // factory stage is upstream, only its outputs enter here
  idzgb_gyro_corr u_corr (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n_ff),
    .smp_tick    (smp_tick_ff),
    .rate_in     ({gyro_z_fact, gyro_y_fact, gyro_x_fact}),
    .bias_in     (bias_pair),
    .rate_out_ff (rate_corr)
  );

  idzgb_dvel_integ u_integ (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n_ff),
    .smp_tick    (smp_tick_ff),
    .accel_smp   (accel_z_smp),
    .dec_set     (decimation_setting),
    .dvel_ff     (dvel_ff),
    .dvel_vld_ff (dvel_vld_ff)
  );

  // ****************************************************************
  // read path, one cycle after the strobe
  // ****************************************************************
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        rvalid_ff;

  // unmapped words, factory terms among them, read as zero
  always_comb begin
    nxt_rdata = RD_IDLE;
    if (word_idx == ADDR_DVZ_LO[6:1]) begin
      nxt_rdata = dvel_ff[15:0];
    end else if (word_idx == ADDR_DVZ_HI[6:1]) begin
      nxt_rdata = dvel_ff[31:16];
    end else if (bias_hit) begin
      nxt_rdata = bias_ff[bias_idx[2:0]];
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff  <= RD_IDLE;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  assign reg_rdata   = rdata_ff;
  assign reg_rvalid  = rvalid_ff;
  assign gyro_x_corr = rate_corr[0];
  assign gyro_y_corr = rate_corr[1];
  assign gyro_z_corr = rate_corr[2];
  assign dvel_z      = dvel_ff;
  assign data_rdy    = dvel_vld_ff;
  assign smp_tick    = smp_tick_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_ff);

  property p_dvlo_read;
    reg_rd && word_idx == ADDR_DVZ_LO[6:1] |=> reg_rvalid && reg_rdata == $past(dvel_ff[15:0]);
  endproperty
  a_dvlo_read: assert property (p_dvlo_read) else $error("low word read wrong");

  property p_dvhi_read;
    reg_rd && word_idx == ADDR_DVZ_HI[6:1] |=> reg_rdata == $past(dvel_ff[31:16]);
  endproperty
  a_dvhi_read: assert property (p_dvhi_read) else $error("main word read wrong");

  property p_dv_ro;
    reg_wr && (word_idx == ADDR_DVZ_LO[6:1] || word_idx == ADDR_DVZ_HI[6:1]) && !smp_tick_ff |=> $stable(dvel_ff);
  endproperty
  a_dv_ro: assert property (p_dv_ro) else $error("host write changed delta velocity");

  property p_tick_period;
    smp_tick_ff |-> tick_cnt_ff == 16'h0000 ##1 !smp_tick_ff [*3];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample tick spacing wrong");

  property p_unmapped_zero;
    reg_rd && !bias_hit && word_idx != ADDR_DVZ_LO[6:1] && word_idx != ADDR_DVZ_HI[6:1] |=> reg_rdata == RD_IDLE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_gx_write;
    reg_wr && word_idx == ADDR_GX_HI[6:1] |=> bias_ff[1] == $past(reg_wdata);
  endproperty
  a_gx_write: assert property (p_gx_write) else $error("x bias high not stored");

  property p_gy_write;
    reg_wr && word_idx == ADDR_GY_LO[6:1] |=> bias_ff[2] == $past(reg_wdata) && $stable(bias_ff[0]) && $stable(bias_ff[5]);
  endproperty
  a_gy_write: assert property (p_gy_write) else $error("y bias write wrong or leaked");

  property p_gz_write;
    reg_wr && word_idx == ADDR_GZ_HI[6:1] |=> bias_ff[5] == $past(reg_wdata) && $stable(bias_pair[0]);
  endproperty
  a_gz_write: assert property (p_gz_write) else $error("z bias write wrong or leaked");

  logic [31:0] gx_wrap;

  // plain wrapped sum, only trusted when the operands cannot overflow
  assign gx_wrap = gyro_x_fact + bias_pair[0];

  property p_bias_apply;
    smp_tick_ff && !(gyro_x_fact[31] == bias_pair[0][31] && gx_wrap[31] != gyro_x_fact[31])
      |=> gyro_x_corr == $past(gx_wrap);
  endproperty
  a_bias_apply: assert property (p_bias_apply) else $error("x correction not rate plus bias");

  property p_no_cross;
    reg_wr && word_idx == ADDR_GX_LO[6:1] |=> $stable(bias_pair[1]) && $stable(bias_pair[2]);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("x write touched other axes");

  property p_readback;
    reg_wr && bias_hit ##2 reg_rd && !$past(reg_wr) && reg_addr[6:1] == $past(reg_addr[6:1], 2)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("bias readback mismatch");

  c_bias_write: cover property (reg_wr && bias_hit);
  c_dv_ready:   cover property (data_rdy ##[1:20] reg_rd && word_idx == ADDR_DVZ_HI[6:1]);
  c_sat:        cover property (data_rdy && dvel_ff == SAT_MAX);
  c_tick_write: cover property (smp_tick_ff && reg_wr && bias_hit);

endmodule
`default_nettype wire

// File: idzgb_pkg.sv
// ****************************************************************
// shared constants for the z delta velocity and gyro bias bank
// ****************************************************************
package idzgb_pkg;

  // ****************************************************************
  // register byte addresses (word registers sit at even addresses)
  // ****************************************************************
  localparam logic [6:0]  ADDR_DVZ_LO   = 7'h38;
  localparam logic [6:0]  ADDR_DVZ_HI   = 7'h3a;
  localparam logic [6:0]  ADDR_GX_LO    = 7'h40;
  localparam logic [6:0]  ADDR_GX_HI    = 7'h42;
  localparam logic [6:0]  ADDR_GY_LO    = 7'h44;
  localparam logic [6:0]  ADDR_GY_HI    = 7'h46;
  localparam logic [6:0]  ADDR_GZ_LO    = 7'h48;
  localparam logic [6:0]  ADDR_GZ_HI    = 7'h4a;

  // ****************************************************************
  // reset values and data formats
  // ****************************************************************
  localparam logic [15:0] BIAS_RST      = 16'h0000;
  localparam logic [31:0] DV_RST        = 32'h0000_0000;
  localparam logic [15:0] RD_IDLE       = 16'h0000;
  localparam logic [31:0] SAT_MAX       = 32'h7fff_ffff;
  localparam logic [31:0] SAT_MIN       = 32'h8000_0000;
  localparam int          NUM_AXES      = 3;
  localparam int          NUM_BIAS_WORDS = 6;
  // halving of the trapezoid sum, accel samples arrive pre-scaled by 1/fs
  localparam int          DV_SHIFT      = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          SAMPLE_HZ     = 2000;
  localparam int          SMP_CYC       = CLK_HZ / SAMPLE_HZ;

endpackage

// File: idzgb_dvel_integ.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// trapezoidal delta velocity integrator, one axis
// ****************************************************************
module idzgb_dvel_integ
  import idzgb_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // sample stream
  input  wire logic        smp_tick,
  input  wire logic [31:0] accel_smp,
  input  wire logic [15:0] dec_set,
  // result
  output logic      [31:0] dvel_ff,
  output logic             dvel_vld_ff
);

  logic signed [47:0] sum_ff;
  logic signed [47:0] nxt_sum;
  logic signed [47:0] total;
  logic signed [47:0] scaled;
  logic signed [31:0] prev_ff;
  logic        [15:0] cnt_ff;
  logic               last;
  logic        [31:0] nxt_dvel;

  // sum of this and previous sample, then halved
  always_comb begin
    total  = sum_ff + 48'(signed'(accel_smp)) + 48'(signed'(prev_ff));
    scaled = total >>> DV_SHIFT;
    last   = (cnt_ff == dec_set);
    nxt_sum = last ? 48'sh0 : total;
    // clip to 32 bits so the high word alone also saturates
    if (scaled > 48'(signed'(SAT_MAX))) begin
      nxt_dvel = SAT_MAX;
    end else if (scaled < 48'(signed'(SAT_MIN))) begin
      nxt_dvel = SAT_MIN;
    end else begin
      nxt_dvel = scaled[31:0];
    end
  end

  // accumulation over the decimation interval
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff  <= 48'sh0;
      prev_ff <= 32'sh0;
      cnt_ff  <= 16'h0000;
    end else if (smp_tick) begin
      sum_ff  <= nxt_sum;
      prev_ff <= signed'(accel_smp);
      cnt_ff  <= last ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  // result published once per interval
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dvel_ff     <= DV_RST;
      dvel_vld_ff <= 1'b0;
    end else begin
      dvel_vld_ff <= smp_tick && last;
      if (smp_tick && last) begin
        dvel_ff <= nxt_dvel;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_sat_pos;
    smp_tick && last && (scaled > 48'(signed'(SAT_MAX))) |=> dvel_ff == SAT_MAX && dvel_ff[31:16] == 16'h7fff;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive overflow not clipped");

  property p_vld_needs_tick;
    dvel_vld_ff |-> $past(smp_tick) && $past(cnt_ff) == $past(dec_set);
  endproperty
  a_vld_needs_tick: assert property (p_vld_needs_tick) else $error("result outside interval end");

endmodule
`default_nettype wire

// File: idzgb_gyro_corr.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// user bias stage, after the factory corrected rates
// ****************************************************************
module idzgb_gyro_corr
  import idzgb_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // sample stream
  input  wire logic                      smp_tick,
  input  wire logic [NUM_AXES-1:0][31:0] rate_in,
  input  wire logic [NUM_AXES-1:0][31:0] bias_in,
  // corrected rates
  output logic      [NUM_AXES-1:0][31:0] rate_out_ff
);

  genvar ax;
  generate
    for (ax = 0; ax < NUM_AXES; ax++) begin : g_axis
      logic signed [32:0] sum;
      logic        [31:0] nxt_rate;

      // saturating add keeps a large bias from wrapping the rate
      always_comb begin
        sum = 33'(signed'(rate_in[ax])) + 33'(signed'(bias_in[ax]));
        if (sum > 33'(signed'(SAT_MAX))) begin
          nxt_rate = SAT_MAX;
        end else if (sum < 33'(signed'(SAT_MIN))) begin
          nxt_rate = SAT_MIN;
        end else begin
          nxt_rate = sum[31:0];
        end
      end

      // one update per processed sample
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          rate_out_ff[ax] <= DV_RST;
        end else if (smp_tick) begin
          rate_out_ff[ax] <= nxt_rate;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: idzgb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// host side model, word accesses handed over by the serial engine
// ****************************************************************
module idzgb_host_model (
  // clock
  input  wire logic        clk_sys,
  // register port
  output logic      [6:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // strobes idle from time zero
  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // one word write, stored at the rising edge after it is raised
  task automatic wr(input logic [6:0] addr, input logic [15:0] data);
    @(negedge clk_sys);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    // released lines flip so a stale value never looks live
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // one word read, valid stands for a single cycle and the answer is taken there
  task automatic rd(input logic [6:0] addr, output logic [15:0] data, output logic vld);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
    vld      = reg_rvalid;
    data     = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import idzgb_pkg::*;
;
  localparam int SMP = 8;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [6:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [31:0] accel_z_smp = 32'h0000_0000;
  logic [31:0] gfact [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [31:0] gcorr [3];
  logic [31:0] g_exp [3];
  logic [15:0] dec = 16'h0000;
  logic [31:0] dvel_z;
  logic        data_rdy;
  logic        smp_tick;
  logic [31:0] hist [10];
  logic [15:0] bias_sh [6];
  logic [31:0] seed = 32'h9bdb15a7;
  logic [31:0] acc_val = 32'h0000_0000;
  logic        acc_fixed = 1'b0;
  logic        dv_chk = 1'b0;
  logic        g_pend = 1'b0;
  logic        seen_tick = 1'b0;
  int          gap = 0;
  int          failures = 0;
  int          comparisons = 0;

  idzgb_regs #(.SMP_CYC_P(SMP)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .accel_z_smp(accel_z_smp),
    .gyro_x_fact(gfact[0]), .gyro_y_fact(gfact[1]), .gyro_z_fact(gfact[2]), .decimation_setting(dec),
    .gyro_x_corr(gcorr[0]), .gyro_y_corr(gcorr[1]), .gyro_z_corr(gcorr[2]), .dvel_z(dvel_z),
    .data_rdy(data_rdy), .smp_tick(smp_tick));

  idzgb_host_model host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // helpers: random source, expectations, compare and verdict
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] clip(input logic signed [39:0] s);
    if (s > 40'sh00_7fff_ffff) return SAT_MAX;
    if (s < -40'sh00_8000_0000) return SAT_MIN;
    return s[31:0];
  endfunction

  // trapezoid over the last d ticks, newest sample first in the history
  function automatic logic [31:0] dv_exp(input int d);
    logic signed [39:0] s;
    s = '0;
    for (int k = 0; k < d; k++) begin
      s += ($signed({{8{hist[k][31]}}, hist[k]}) + $signed({{8{hist[k+1][31]}}, hist[k+1]})) >>> 1;
    end
    return clip(s);
  endfunction

  function automatic logic [15:0] exp_reg(input logic [6:0] a);
    if (a >= ADDR_GX_LO && a < ADDR_GZ_HI + 7'h2) return bias_sh[(a - ADDR_GX_LO) >> 1];
    return RD_IDLE;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bounded wait for n update pulses; a hang ends the run
  task automatic wait_rdy(input int n);
    int t;
    for (int j = 0; j < n; j++) begin
      t = 0;
      @(negedge clk_sys);
      while (data_rdy !== 1'b1) begin
        t++;
        if (t > 200) begin
          failures++;
          print_verdict();
        end
        @(negedge clk_sys);
      end
    end
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    rstn   = 1'b0;
    dv_chk = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  // ****************************************************************
  // shadow of the bias words, taken at the edge that stores a write
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rstn) begin
      foreach (bias_sh[k]) bias_sh[k] <= BIAS_RST;
    end else if (reg_wr === 1'b1 && reg_addr >= ADDR_GX_LO && reg_addr < ADDR_GZ_HI + 7'h2) begin
      bias_sh[(reg_addr - ADDR_GX_LO) >> 1] <= reg_wdata;
    end
  end

  // sample stream: check last results, draw the inputs taken at the next edge, record them
  always @(negedge clk_sys) begin
    if (!rstn) begin
      foreach (hist[k]) hist[k] = 32'h0000_0000;
      g_pend    = 1'b0;
      seen_tick = 1'b0;
      gap       = 0;
    end else begin
      gap++;
      if (g_pend) begin
        for (int i = 0; i < 3; i++) check("gyro corr", gcorr[i], g_exp[i]);
        g_pend = 1'b0;
      end
      if (data_rdy === 1'b1 && dv_chk) check("dvel", dvel_z, dv_exp(int'(dec) + 1));
      if (smp_tick === 1'b1) begin
        if (seen_tick) check("tick gap", gap, SMP);
        gap       = 0;
        seen_tick = 1'b1;
        for (int k = 9; k > 0; k--) hist[k] = hist[k-1];
        // the design samples these at the rising edge that ends this tick cycle
        for (int i = 0; i < 3; i++) begin
          gfact[i] = rnd();
          g_exp[i] = clip($signed({{8{gfact[i][31]}}, gfact[i]}) +
                          $signed({{8{bias_sh[2*i+1][15]}}, bias_sh[2*i+1], bias_sh[2*i]}));
        end
        g_pend = 1'b1;
        // random samples stay even and small so the halving never rounds
        accel_z_smp = acc_fixed ? acc_val : {{5{seed[31]}}, seed[26:1], 1'b0};
        hist[0] = accel_z_smp;
        seed = rnd();
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] v;
    logic        ok;
    logic [31:0] dv;
    logic [15:0] dec_tab [6];
    dec_tab = '{16'h0000, 16'h0001, 16'h0007, 16'h0003, 16'h0002, 16'h0002};
    do_reset();
    // every word address except 0x38 and 0x3a: defaults, nothing hidden answers
    for (int a = 0; a < 128; a += 2) begin
      if (a != 'h38 && a != 'h3a) begin
        host.rd(7'(a), v, ok);
        check("rvalid", ok, 1'b1);
        check("reg read", v, exp_reg(7'(a)));
      end
    end
    // bias words one at a time, all six read back after each write
    for (int i = 0; i < 6; i++) begin
      host.wr(ADDR_GX_LO + 7'(2 * i), 16'(rnd()));
      for (int k = 0; k < 6; k++) begin
        host.rd(ADDR_GX_LO + 7'(2 * k) + 7'(k % 2), v, ok);
        check("bias word", v, bias_sh[k]);
      end
    end
    host.wr(7'h4c, 16'h5a5a);
    host.rd(7'h4c, v, ok);
    check("unmapped", v, RD_IDLE);
    // delta velocity: interval lengths, then clipped and zero inputs
    for (int m = 0; m < 6; m++) begin
      dec       = dec_tab[m];
      acc_fixed = (m >= 3);
      acc_val   = (m == 3) ? 32'h6000_0000 : (m == 4) ? 32'ha000_0000 : 32'h0000_0000;
      dv_chk    = 1'b0;
      wait_rdy(2);
      dv_chk = 1'b1;
      wait_rdy(3);
      if (m > 0) begin
        dv = dv_exp(int'(dec) + 1);
        host.wr(ADDR_DVZ_LO, 16'(rnd()));
        host.wr(ADDR_DVZ_HI + 7'h1, 16'(rnd()));
        host.rd(ADDR_DVZ_LO, v, ok);
        check("dvel low word", v, dv[15:0]);
        host.rd(ADDR_DVZ_HI, v, ok);
        check("dvel main word", v, dv[31:16]);
        if (m >= 3) check("main word view", v, (m == 3) ? 16'h7fff : (m == 4) ? 16'h8000 : 16'h0000);
      end
    end
    // second reset in mid-run brings every bias word back to zero
    do_reset();
    for (int k = 0; k < 6; k++) begin
      host.rd(ADDR_GX_LO + 7'(2 * k), v, ok);
      check("bias after reset", v, BIAS_RST);
    end
    wait_rdy(2);
    print_verdict();
  end
endmodule
`default_nettype wire
